// [logic/osc_select_clock_config.sv]
// Clock source selection and clock configuration register.
// Assumes the reset sources and suspend/wake events arrive as one-cycle
// pulses on the system clock; oscillator stable flag arrives from a pin.
`timescale 1ns/1ns

// Operation
// - Writing ext enable starts switch to external; repeat writes start nothing.
// - Clearing ext enable takes effect only at suspend wake.
// - Ext enable zero: osc input is pulled-down input, read at aux bit 1.
// - Output disable drives osc output high; ignored in external mode.
// - Precision USB bit tunes internal oscillator; ignored in external mode.
// - Low-voltage reset disable bit turns off the low-voltage reset circuit.
// - Wake-up timer adjust bits go to the wake-up timer.
// - Resume delay bit: 128 us when zero, 4 ms when one.
// - Internal-oscillator wake releases CPU after 1 us start plus 8 us.
// - Register resets to zero; every bit position holds a field.
// - Power-up runs internal clock, buffered to osc output by default.
// - Switch stops internal clock, enables external, re-enables when stable.
// - CPU halted through switch until stable and delay expired.
// - Osc input level never raises CPU interrupts.
// - Internal oscillator gives nominal 6 MHz with no external parts.
// - Register decoded at I/O address 0xF8.
// - Watchdog reset clears ext enable but keeps clock mode.
// - Low-voltage or brown-out reset forces internal mode immediately.
module osc_select_clock_config
   import clkcfg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Reset sources
   input wire logic i_watchdog_reset,
   input wire logic i_brownout_reset,
   // I/O instruction port
   input wire logic i_io_rd,
   input wire logic i_io_wr,
   input wire logic [7:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   output logic [7:0] o_io_rdata,
   output logic o_io_hit,
   // Suspend control
   input wire logic i_suspend_enter,
   input wire logic i_wake,
   // Oscillator pins and status
   input wire logic i_osc_in_pin,
   input wire logic i_ext_osc_stable,
   output logic o_osc_out_pin,
   output logic o_osc_in_pulldown,
   output logic o_aux_input_bit1,
   // Clock control
   output clk_ctl_type o_clk_ctl,
   output logic o_low_voltage_reset_en,
   output logic [2:0] o_wake_adjust
);

   // ****************************************
   // Register and decode
   // ****************************************
   logic [7:0] clock_configuration;
   wire [7:0] next_clock_configuration;
   clk_state_type state;
   clk_state_type next_state;
   io_req_type req;
   logic osc_in_meta;
   logic osc_in_sync;
   logic stable_meta;
   logic stable_sync;
   logic int_clk_div;
   logic [1:0] div_cnt;
   logic wake_int_pending;
   logic [4:0] int_start_cnt;

   assign req = '{rd: i_io_rd, wr: i_io_wr, addr: i_io_addr, wdata: i_io_wdata};
   wire sel_cfg = (req.addr == ADDR_CLOCK_CONFIGURATION);
   wire cfg_wr = req.wr && sel_cfg;
   wire cfg_rd = req.rd && sel_cfg;
   wire cfg_access = cfg_rd || cfg_wr;
   // Reset sources only ever clear the enable bit
   wire clear_ext_en = i_watchdog_reset || i_brownout_reset;
   // Only positions with a function are stored
   wire [7:0] write_value = req.wdata & CLOCK_CONFIGURATION_WMASK;

   // ****************************************
   // Register fields
   // ****************************************
   wire ext_en = clock_configuration[BIT_EXT_OSC_EN];
   wire out_dis = clock_configuration[BIT_INT_CLK_OUT_DIS];
   wire precision_en = clock_configuration[BIT_PRECISION_USB];
   wire lvr_dis = clock_configuration[BIT_LVR_DIS];
   wire [2:0] wake_adj = clock_configuration[BIT_WAKE_ADJ_LO +: 3];
   wire resume_long = clock_configuration[BIT_RESUME_DELAY];
   wire ext_mode = (state != ST_INT_RUN) && !(state == ST_SUSPEND && !ext_en);
   wire in_ext = (state == ST_EXT_START) || (state == ST_EXT_DELAY) || (state == ST_EXT_RUN);
   // Rising edge only; a rewrite of one while set is no new switch
   wire ext_rise = cfg_wr && req.wdata[BIT_EXT_OSC_EN] && !ext_en;

   // ****************************************
   // Register next value
   // ****************************************
   // Reset-source clear of the enable bit beats a same-cycle write
   for (genvar b = 0; b < 8; b++) begin : g_cfg_bit
      if (b == BIT_EXT_OSC_EN) begin : g_enable
         assign next_clock_configuration[b] = clear_ext_en ? 1'b0
                                            : cfg_wr ? write_value[b]
                                            : clock_configuration[b];
      end else begin : g_field
         assign next_clock_configuration[b] = cfg_wr ? write_value[b]
                                            : clock_configuration[b];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         clock_configuration <= CLOCK_CONFIGURATION_RESET;
      end else begin
         clock_configuration <= next_clock_configuration;
      end
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         osc_in_meta <= 1'b0;
         osc_in_sync <= 1'b0;
         stable_meta <= 1'b0;
         stable_sync <= 1'b0;
      end else begin
         osc_in_meta <= i_osc_in_pin;
         osc_in_sync <= osc_in_meta;
         stable_meta <= i_ext_osc_stable;
         stable_sync <= stable_meta;
      end
   end

   // ****************************************
   // Source selection sequence
   // ****************************************
   logic timer_start;
   logic timer_done;
   logic [CNT_W-1:0] timer_load;
   wire int_started = wake_int_pending && (int_start_cnt == 5'(OSC_START_INT_CYC - 1));

   always_comb begin
      next_state = state;
      timer_start = 1'b0;
      timer_load = resume_long ? CNT_W'(DELAY_LONG_CYC)
                               : CNT_W'(DELAY_SHORT_CYC);
      case (state)
         ST_INT_RUN: begin
            if (ext_rise) begin
               next_state = ST_EXT_START;
            end else if (i_suspend_enter) begin
               next_state = ST_SUSPEND;
            end
         end
         ST_EXT_START: begin
            if (stable_sync) begin
               next_state = ST_EXT_DELAY;
               timer_start = 1'b1;
            end
         end
         ST_EXT_DELAY: begin
            if (timer_done) begin
               next_state = ST_EXT_RUN;
            end
         end
         ST_EXT_RUN: begin
            if (i_suspend_enter) begin
               next_state = ST_SUSPEND;
            end
         end
         ST_SUSPEND: begin
            if (i_wake && ext_en) begin
               next_state = ST_EXT_START;
            end else if (int_started) begin
               timer_load = CNT_W'(DELAY_INT_WAKE_CYC);
               timer_start = 1'b1;
            end else if (timer_done) begin
               next_state = ST_INT_RUN;
            end
         end
         default: next_state = ST_INT_RUN;
      endcase
      if (i_brownout_reset) begin
         next_state = ST_INT_RUN;
         timer_start = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state <= ST_INT_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Internal oscillator start-up window after wake
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_brownout_reset || int_started) begin
         wake_int_pending <= 1'b0;
         int_start_cnt <= '0;
      end else if (state == ST_SUSPEND && i_wake && !ext_en) begin
         wake_int_pending <= 1'b1;
      end else if (wake_int_pending) begin
         int_start_cnt <= int_start_cnt + 5'd1;
      end
   end

   resume_timer u_resume_timer (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst || i_brownout_reset),
      .i_start(timer_start),
      .i_load(timer_load),
      .o_done(timer_done)
   );

   // ****************************************
   // Internal clock image on the output pin
   // ****************************************
   // Nominal 6 MHz internal clock imaged by a divide-by-6 of the system clock, about 3.3 MHz
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         div_cnt <= '0;
         int_clk_div <= 1'b0;
      end else begin
         div_cnt <= (div_cnt == 2'd2) ? 2'd0 : div_cnt + 2'd1;
         if (div_cnt == 2'd2) begin
            int_clk_div <= ~int_clk_div;
         end
      end
   end

   wire int_active = !in_ext && (state != ST_SUSPEND);
   wire next_osc_out = !int_active ? 1'b0
                     : out_dis ? 1'b1
                     : int_clk_div;
   clk_ctl_type next_ctl;
   assign next_ctl.ext_osc_en = in_ext || (state == ST_SUSPEND && ext_en && i_wake);
   assign next_ctl.int_osc_en = int_active || wake_int_pending;
   assign next_ctl.use_ext_clk = (state == ST_EXT_DELAY) || (state == ST_EXT_RUN);
   assign next_ctl.cpu_halt = (state != ST_INT_RUN) && (state != ST_EXT_RUN);
   assign next_ctl.precision_tune = precision_en && !ext_mode;

   // ****************************************
   // I/O read port
   // ****************************************
   // Other addresses read as zero so the shared read bus stays clean
   wire [7:0] next_rdata = cfg_rd ? clock_configuration : 8'h00;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_io_rdata <= 8'h00;
         o_io_hit <= 1'b0;
      end else begin
         o_io_rdata <= next_rdata;
         o_io_hit <= cfg_access;
      end
   end

   // ****************************************
   // Pin outputs
   // ****************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_osc_out_pin <= 1'b0;
         o_osc_in_pulldown <= 1'b1;
         o_aux_input_bit1 <= 1'b0;
      end else begin
         o_osc_out_pin <= next_osc_out;
         o_osc_in_pulldown <= !ext_en;
         // Plain data only; never routed to interrupt logic
         o_aux_input_bit1 <= !ext_en && osc_in_sync;
      end
   end

   // ****************************************
   // Control outputs
   // ****************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_clk_ctl <= '0;
      end else begin
         o_clk_ctl <= next_ctl;
      end
   end

   // ****************************************
   // Configuration outputs
   // ****************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_low_voltage_reset_en <= 1'b1;
         o_wake_adjust <= 3'h0;
      end else begin
         o_low_voltage_reset_en <= !lvr_dis;
         o_wake_adjust <= wake_adj;
      end
   end

endmodule

// [logic/clkcfg_pkg.sv]
// Package for the clock source selection and configuration block.
// Assumes a 20 MHz system clock; the oscillators themselves are analogue.
package clkcfg_pkg;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [7:0] ADDR_CLOCK_CONFIGURATION = 8'hf8;
   localparam logic [7:0] CLOCK_CONFIGURATION_RESET = 8'h00;
   localparam logic [7:0] CLOCK_CONFIGURATION_WMASK = 8'hff;
   localparam int BIT_EXT_OSC_EN = 0;
   localparam int BIT_INT_CLK_OUT_DIS = 1;
   localparam int BIT_PRECISION_USB = 2;
   localparam int BIT_LVR_DIS = 3;
   localparam int BIT_WAKE_ADJ_LO = 4;
   localparam int BIT_RESUME_DELAY = 7;
   localparam int AUX_INPUT_BIT = 1;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 20;
   localparam int INT_OSC_MHZ = 6;
   localparam int DELAY_SHORT_US = 128;
   localparam int DELAY_LONG_MS = 4;
   localparam int DELAY_INT_WAKE_US = 8;
   localparam int OSC_START_INT_US = 1;
   localparam int DELAY_SHORT_CYC = DELAY_SHORT_US * CLK_MHZ;
   localparam int DELAY_LONG_CYC = DELAY_LONG_MS * 1000 * CLK_MHZ;
   localparam int DELAY_INT_WAKE_CYC = DELAY_INT_WAKE_US * CLK_MHZ;
   localparam int OSC_START_INT_CYC = OSC_START_INT_US * CLK_MHZ;
   localparam int CNT_W = 17;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [4:0] {
      ST_INT_RUN = 5'b00001,
      ST_EXT_START = 5'b00010,
      ST_EXT_DELAY = 5'b00100,
      ST_EXT_RUN = 5'b01000,
      ST_SUSPEND = 5'b10000
   } clk_state_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } io_req_type;

   typedef struct packed {
      logic ext_osc_en;
      logic int_osc_en;
      logic use_ext_clk;
      logic cpu_halt;
      logic precision_tune;
   } clk_ctl_type;

endpackage

// [logic/resume_timer.sv]
// Resume delay counter.
// Assumes start is a one-cycle pulse; the load value is sampled only at start.
`timescale 1ns/1ns
module resume_timer
   import clkcfg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Control
   input wire logic i_start,
   input wire logic [CNT_W-1:0] i_load,
   // Status
   output logic o_done
);

   logic [CNT_W-1:0] count;
   logic running;
   wire last = running && (count == {CNT_W{1'b0}});

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || last) begin
         running <= 1'b0;
         count <= '0;
      end else if (i_start) begin
         running <= 1'b1;
         count <= i_load - CNT_W'(1);
      end else if (running) begin
         count <= count - CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= last;
      end
   end

endmodule

// [testbench/clkcfg_sva.sv]
// Checker for the clock source selection and configuration block.
// Sees only the block's ports; bound to it below the module.
`timescale 1ns/1ns
module clkcfg_sva
   import clkcfg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Inputs
   input wire logic i_brownout_reset,
   input wire logic i_io_rd,
   input wire logic i_io_wr,
   input wire logic [7:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   input wire logic i_ext_osc_stable,
   // Outputs
   input wire logic [7:0] o_io_rdata,
   input wire logic o_io_hit,
   input wire logic o_osc_in_pulldown,
   input wire logic o_aux_input_bit1,
   input wire clk_ctl_type o_clk_ctl,
   input wire logic o_low_voltage_reset_en,
   input wire logic [2:0] o_wake_adjust
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   logic [16:0] stab_cnt;
   wire sel = i_io_addr == ADDR_CLOCK_CONFIGURATION;
   // Cycles of stable external clock while halted
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !(o_clk_ctl.cpu_halt && o_clk_ctl.ext_osc_en && i_ext_osc_stable))
         stab_cnt <= 17'h0;
      else
         stab_cnt <= stab_cnt + 17'h1;
   end
   a_lvr_follow: assert property (
      i_io_wr && sel ##1 !i_io_wr |=> o_low_voltage_reset_en == !$past(i_io_wdata[3], 2))
      else $error("low voltage reset enable wrong");
   a_wake_follow: assert property (
      i_io_wr && sel ##1 !i_io_wr |=> o_wake_adjust == $past(i_io_wdata[6:4], 2))
      else $error("wake adjust wrong");
   a_hit_pulse: assert property ((i_io_rd || i_io_wr) && sel |=> o_io_hit)
      else $error("access not acknowledged");
   a_rdata_other: assert property (i_io_rd && !sel |=> o_io_rdata == 8'h00)
      else $error("foreign address returned data");
   a_aux_gated: assert property (!o_osc_in_pulldown |-> !o_aux_input_bit1)
      else $error("aux input live in external mode");
   a_ext_halt: assert property (
      $rose(o_clk_ctl.ext_osc_en) |-> o_clk_ctl.cpu_halt && !o_clk_ctl.int_osc_en)
      else $error("switch did not halt cpu");
   a_resume_min: assert property (
      $fell(o_clk_ctl.cpu_halt) && o_clk_ctl.ext_osc_en |-> stab_cnt >= DELAY_SHORT_CYC)
      else $error("cpu released too early");
   a_bor_internal: assert property (
      i_brownout_reset |-> ##[1:2] (o_clk_ctl.int_osc_en && !o_clk_ctl.ext_osc_en))
      else $error("brownout left external mode");
   a_power_up: assert property ($fell(i_rst) |-> ##[0:2] o_clk_ctl.int_osc_en)
      else $error("no internal clock after reset");
   a_prec_ext_off: assert property (o_clk_ctl.ext_osc_en |-> !o_clk_ctl.precision_tune)
      else $error("precision tune active in external mode");
endmodule
bind osc_select_clock_config clkcfg_sva u_sva (
   .i_clk_sys, .i_rst, .i_brownout_reset, .i_io_rd, .i_io_wr, .i_io_addr, .i_io_wdata,
   .i_ext_osc_stable, .o_io_rdata, .o_io_hit, .o_osc_in_pulldown, .o_aux_input_bit1,
   .o_clk_ctl, .o_low_voltage_reset_en, .o_wake_adjust
);

// [testbench/ext_osc_model.sv]
// External resonator model: stable a start-up time after enable.
// Assumes enable follows the block's external oscillator control.
`timescale 1ns/1ns
module ext_osc_model #(
   parameter int START_CYC = 40
) (
   // Clock
   input wire logic i_clk_sys,
   // Control
   input wire logic i_enable,
   // Status
   output logic o_stable
);
   int cnt = 0;
   initial o_stable = 1'h0;
   always @(posedge i_clk_sys) begin
      cnt <= i_enable ? cnt + 1 : 0;
      o_stable <= i_enable && cnt >= START_CYC;
   end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the clock configuration block.
// Assumes a 20 MHz clock and the resonator model on the far side.
`timescale 1ns/1ns
module testbench
   import clkcfg_pkg::*;
;
   logic i_clk_sys = 1'h0, i_rst = 1'h1, i_watchdog_reset = 1'h0, i_brownout_reset = 1'h0;
   logic i_io_rd = 1'h0, i_io_wr = 1'h0, i_suspend_enter = 1'h0, i_wake = 1'h0;
   logic i_osc_in_pin = 1'h0, i_ext_osc_stable, o_io_hit, o_osc_out_pin, o_osc_in_pulldown;
   logic o_aux_input_bit1, o_low_voltage_reset_en;
   logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00, o_io_rdata;
   logic [2:0] o_wake_adjust;
   clk_ctl_type o_clk_ctl;
   int errors = 0, checked = 0;
   localparam logic [7:0] CFG = ADDR_CLOCK_CONFIGURATION;
   always #25 i_clk_sys = ~i_clk_sys;
   osc_select_clock_config DUT (.i_clk_sys, .i_rst, .i_watchdog_reset, .i_brownout_reset,
      .i_io_rd, .i_io_wr, .i_io_addr, .i_io_wdata, .o_io_rdata, .o_io_hit, .i_suspend_enter,
      .i_wake, .i_osc_in_pin, .i_ext_osc_stable, .o_osc_out_pin, .o_osc_in_pulldown,
      .o_aux_input_bit1, .o_clk_ctl, .o_low_voltage_reset_en, .o_wake_adjust);
   ext_osc_model #(.START_CYC(40)) osc (.i_clk_sys, .i_enable(o_clk_ctl.ext_osc_en),
      .o_stable(i_ext_osc_stable));
   // ******************
   // Shared tasks
   // ******************
   task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
      checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
         errors++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_io_wr <= 1'h1;
      i_io_addr <= a;
      i_io_wdata <= d;
      @(posedge i_clk_sys);
      i_io_wr <= 1'h0;
      cyc(2);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge i_clk_sys);
      i_io_rd <= 1'h1;
      i_io_addr <= a;
      @(posedge i_clk_sys);
      i_io_rd <= 1'h0;
      #1;
      d = o_io_rdata;
      h = o_io_hit;
   endtask
   // Watchdog, brownout, suspend, wake as one-cycle pulses
   task automatic pulse(input logic [3:0] v);
      @(posedge i_clk_sys);
      {i_watchdog_reset, i_brownout_reset, i_suspend_enter, i_wake} <= v;
      @(posedge i_clk_sys);
      {i_watchdog_reset, i_brownout_reset, i_suspend_enter, i_wake} <= 4'h0;
      cyc(3);
   endtask
   task automatic wait_run(output int n);
      n = 0;
      while (o_clk_ctl.cpu_halt !== 1'h0 && n < 5000) begin
         cyc(1);
         n++;
      end
   endtask
   // ******************
   // Scenarios
   // ******************
   task automatic t_reset();
      logic [7:0] d;
      logic h;
      logic s0 = 1'h0;
      logic s1 = 1'h0;
      repeat (12) begin
         cyc(1);
         s0 |= !o_osc_out_pin;
         s1 |= o_osc_out_pin;
      end
      chk("out_clock", 1'h1, s0 & s1);
      rd(CFG, d, h);
      chk("cfg", 8'h00, d);
      chk("int_osc", 1'h1, o_clk_ctl.int_osc_en);
      chk("lvr_en", 1'h1, o_low_voltage_reset_en);
   endtask
   task automatic t_fields();
      logic [7:0] d;
      logic h;
      wr(CFG, 8'h7a);
      chk("lvr_en", 1'h0, o_low_voltage_reset_en);
      chk("wake_adj", 3'h7, o_wake_adjust);
      chk("out_high", 1'h1, o_osc_out_pin);
      rd(CFG, d, h);
      chk("cfg", 8'h7a, d);
      wr(CFG, 8'h54);
      chk("wake_adj", 3'h5, o_wake_adjust);
      chk("precision", 1'h1, o_clk_ctl.precision_tune);
      wr(8'hf7, 8'hff);
      rd(8'hf7, d, h);
      chk("other", 8'h00, d);
      chk("other_hit", 1'h0, h);
      rd(CFG, d, h);
      chk("cfg", 8'h54, d);
      chk("hit", 1'h1, h);
   endtask
   task automatic t_aux();
      @(posedge i_clk_sys);
      i_osc_in_pin <= 1'h1;
      cyc(5);
      chk("aux", 1'h1, o_aux_input_bit1);
      chk("pulldown", 1'h1, o_osc_in_pulldown);
      @(posedge i_clk_sys);
      i_osc_in_pin <= 1'h0;
      cyc(5);
      chk("aux", 1'h0, o_aux_input_bit1);
   endtask
   task automatic t_switch();
      logic [7:0] d;
      logic h;
      int n;
      wr(CFG, 8'h03);
      chk("halt", 1'h1, o_clk_ctl.cpu_halt);
      chk("int_off", 5'h12, o_clk_ctl & 5'h1a);
      wait_run(n);
      chk("resume", 1'h1, n >= 2595 && n <= 2620);
      chk("use_ext", 1'h1, o_clk_ctl.use_ext_clk);
      chk("out_ext", 1'h0, o_osc_out_pin);
      chk("pulldown", 1'h0, o_osc_in_pulldown);
      wr(CFG, 8'h03);
      chk("no_restart", 1'h0, o_clk_ctl.cpu_halt);
      pulse(4'h8);
      chk("wdr_keep", 1'h1, o_clk_ctl.use_ext_clk);
      rd(CFG, d, h);
      chk("wdr_clear", 8'h02, d);
      chk("clr_keep", 1'h1, o_clk_ctl.use_ext_clk);
      pulse(4'h2);
      pulse(4'h1);
      wait_run(n);
      chk("int_wake", 1'h1, n >= 170 && n <= 190);
      chk("int_mode", 1'h1, o_clk_ctl.int_osc_en);
   endtask
   task automatic t_brownout();
      logic [7:0] d;
      logic h;
      wr(CFG, 8'h81);
      cyc(100);
      chk("halt", 1'h1, o_clk_ctl.cpu_halt);
      pulse(4'h4);
      chk("bor_mode", 5'h08, o_clk_ctl);
      rd(CFG, d, h);
      chk("bor_cfg", 8'h80, d);
   endtask
   task automatic t_ext_wake();
      int n;
      wr(CFG, 8'h05);
      wait_run(n);
      chk("ext_run", 1'h1, o_clk_ctl.use_ext_clk);
      chk("prec_ext", 1'h0, o_clk_ctl.precision_tune);
      pulse(4'h2);
      chk("susp_halt", 1'h1, o_clk_ctl.cpu_halt);
      pulse(4'h1);
      wait_run(n);
      chk("ext_wake", 1'h1, n >= 2595 && n <= 2620);
      chk("ext_wake_mode", 1'h1, o_clk_ctl.use_ext_clk);
   endtask
   task automatic tally_and_finish();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'h0;
      cyc(1);
      t_reset();
      t_fields();
      t_aux();
      t_switch();
      t_brownout();
      t_ext_wake();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      errors++;
      tally_and_finish();
   end
endmodule
